// *** bench/ss2_card_model.sv ***
// Card-side model: answers reset after a set count of card clock rises and can pull its data line low.
`default_nettype none
module ss2_card_model (
  input  wire logic       clk,
  input  wire logic       card_clock_out,
  input  wire logic       card_reset_release,
  input  wire logic [7:0] answer_delay,
  input  wire logic       answer_enable,
  input  wire logic       pull_low,
  output logic            answer_start,
  output logic            card_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rises = 8'h00;
  logic       armed = 1'b0;
  logic       last  = 1'b0;
  // A silent card never answers, so the mute window can run out.
  always @(posedge clk) begin
    answer_start <= 1'b0;
    last <= card_clock_out;
    if (card_reset_release) begin
      armed <= 1'b1;
      rises <= 8'h00;
    end else if (armed && card_clock_out && !last) begin
      rises <= rises + 8'h01;
      if (answer_enable && (rises + 8'h01) == answer_delay) begin
        answer_start <= 1'b1;
        armed <= 1'b0;
      end
    end
  end
  assign card_pull = pull_low;
endmodule : ss2_card_model
`default_nettype wire

// *** bench/ss2_regs_tb.sv ***
// Self-checking testbench for the second card slot register bank.
`default_nettype none
module ss2_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sic = 1'b0, stable = 1'b0;
  logic       oc = 1'b0, ramp = 1'b0, crr = 1'b0, auto_d = 1'b0, warm_b = 1'b0, pull = 1'b0, ans_en = 1'b0;
  logic       hpull = 1'b0, h_o, c_o;
  logic [7:0] addr = 8'h00, wdata = 8'h00, delay = 8'h00, rdata;
  logic [1:0] vsel;
  logic       sum, act, warm, cclk, ans, cpull, h_oe, c_oe, host_line, card_line;
  logic [7:0] ra [8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
  logic [7:0] rv [8] = '{8'h00, 8'h40, 8'h0C, 8'hAA, 8'h00, 8'hA4, 8'h74, 8'h00};
  int         num_errors = 0, total_checks = 0, n, r, e;
  assign card_line = ~(c_oe | cpull);
  assign host_line = ~(h_oe | hpull);
  ss2_regs uut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(reg_wr), .reg_wdata(wdata), .reg_rd(reg_rd),
    .reg_rdata(rdata), .second_input_clock(sic), .supply_stable(stable), .overcurrent_detect(oc),
    .ramp_fault_detect(ramp), .card_reset_release(crr), .answer_start(ans), .auto_deactivate(auto_d),
    .warm_reset_begun(warm_b), .slot_interrupt_summary(sum), .supply_select(vsel),
    .activation_control(act), .warm_reset_start(warm), .card_clock_out(cclk),
    .host_data_line_i(host_line), .host_data_line_o(h_o), .host_data_line_oe(h_oe),
    .card_data_line_i(card_line), .card_data_line_o(c_o), .card_data_line_oe(c_oe));
  ss2_card_model card (.clk(clk), .card_clock_out(cclk), .card_reset_release(crr), .answer_delay(delay),
    .answer_enable(ans_en), .pull_low(pull), .answer_start(ans), .card_pull(cpull));
  initial forever #12.5 clk = ~clk;
  always @(negedge clk) sic <= ~sic;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check(rdata, exp);
    @(negedge clk);
  endtask : rd
  task automatic count_rises(input int cyc);
    logic last;
    last = cclk;
    r = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (cclk && !last) r++;
      last = cclk;
    end
  endtask : count_rises
  task automatic wait_sum;
    for (n = 0; n < 400 && sum !== 1'b1; n++) @(negedge clk);
    if (n == 400) begin
      num_errors++;
      report_and_stop;
    end
  endtask : wait_sum
  task automatic pulse_release;
    crr = 1'b1;
    @(negedge clk);
    crr = 1'b0;
  endtask : pulse_release
  initial begin
    repeat (50000) @(negedge clk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    check(8'(vsel), 8'h01);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    wr(8'h24, 8'hFF);
    rd(8'h24, 8'hC0);
    wr(8'h23, 8'h55);
    rd(8'h23, 8'h55);
    wr(8'h25, 8'h12);
    wr(8'h26, 8'h34);
    rd(8'h25, 8'h12);
    rd(8'h26, 8'h34);
    wr(8'h27, 8'hFF);
    rd(8'h27, 8'h00);
    for (int v = 0; v < 4; v++) begin
      wr(8'h21, 8'(v << 6));
      check(8'(vsel), 8'(v));
    end
    // Overcurrent then ramp fault: flag, summary, clear on read.
    for (int i = 0; i < 2; i++) begin
      oc = (i == 0);
      ramp = (i == 1);
      @(negedge clk);
      oc = 1'b0;
      ramp = 1'b0;
      check(8'(sum), 8'h01);
      rd(8'h20, (i == 0) ? 8'h10 : 8'h01);
      rd(8'h20, 8'h00);
      check(8'(sum), 8'h00);
    end
    stable = 1'b1;
    wr(8'h21, 8'h01);
    check(8'(act), 8'h01);
    rd(8'h20, 8'h80);
    rd(8'h20, 8'h80);
    auto_d = 1'b1;
    @(negedge clk);
    auto_d = 1'b0;
    rd(8'h21, 8'h00);
    check(8'(act), 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h21, 8'h08);
    check(8'(warm), 8'h01);
    warm_b = 1'b1;
    @(negedge clk);
    warm_b = 1'b0;
    @(negedge clk);
    check(8'(warm), 8'h00);
    rd(8'h21, 8'h00);
    pull = 1'b1;
    repeat (3) @(negedge clk);
    check(8'(h_oe), 8'h00);
    wr(8'h21, 8'h20);
    check(8'(h_oe), 8'h01);
    pull = 1'b0;
    hpull = 1'b1;
    repeat (3) @(negedge clk);
    check({6'h00, h_oe, c_oe}, 8'h01);
    hpull = 1'b0;
    wr(8'h21, 8'h00);
    repeat (3) @(negedge clk);
    check({4'h0, h_o, c_o, h_oe, c_oe}, 8'h00);
    wr(8'h22, 8'h40);
    count_rises(40);
    check({7'h00, cclk} | 8'(r), 8'h00);
    wr(8'h22, 8'h60);
    count_rises(40);
    check({7'h00, cclk} | 8'(r), 8'h00);
    wr(8'h22, 8'h20);
    count_rises(40);
    check({7'h00, cclk} | 8'(r << 1), 8'h01);
    wr(8'h22, 8'h80);
    count_rises(160);
    check(8'(r >= 4 && r <= 6), 8'h01);
    rd(8'h20, 8'h08);
    wr(8'h22, 8'h00);
    rd(8'h20, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h22, 8'(c << 2));
      e = (c == 0) ? 80 : (c == 1) ? 40 : (c == 2) ? 20 : (c == 3) ? 16 : 10;
      count_rises(20);
      count_rises(160);
      check(8'(r >= e - 1 && r <= e + 1), 8'h01);
    end
    // Early limit 4 and mute limit 32 card clock rises at divide by one.
    wr(8'h22, 8'h00);
    wr(8'h23, 8'h01);
    wr(8'h24, 8'h00);
    wr(8'h25, 8'h00);
    wr(8'h26, 8'h20);
    wr(8'h21, 8'h01);
    delay = 8'h02;
    ans_en = 1'b1;
    pulse_release();
    wait_sum();
    rd(8'h20, 8'hC0);
    ans_en = 1'b0;
    pulse_release();
    wait_sum();
    rd(8'h20, 8'hA0);
    delay = 8'h0A;
    ans_en = 1'b1;
    pulse_release();
    repeat (150) @(negedge clk);
    check(8'(sum), 8'h00);
    rd(8'h20, 8'h80);
    report_and_stop();
  end
endmodule : ss2_regs_tb
`default_nettype wire

// *** common/ss2_pkg.sv ***
// Constants for the second card slot register bank.
`default_nettype none
package ss2_pkg;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_SETTINGS = 8'h21;
  localparam logic [7:0] ADDR_CLKSET   = 8'h22;
  localparam logic [7:0] ADDR_EARLY_HI = 8'h23;
  localparam logic [7:0] ADDR_EARLY_LO = 8'h24;
  localparam logic [7:0] ADDR_MUTE_HI  = 8'h25;
  localparam logic [7:0] ADDR_MUTE_LO  = 8'h26;

  localparam int ST_ACTIVE = 7;
  localparam int ST_EARLY  = 6;
  localparam int ST_MUTE   = 5;
  localparam int ST_OC     = 4;
  localparam int ST_INTCLK = 3;
  localparam int ST_RAMP   = 0;

  localparam int SET_VCC_HI = 7;
  localparam int SET_VCC_LO = 6;
  localparam int SET_IOEN   = 5;
  localparam int SET_WARM   = 3;
  localparam int SET_ACT    = 0;

  localparam int CK_INT    = 7;
  localparam int CK_LOW    = 6;
  localparam int CK_HIGH   = 5;
  localparam int CK_DIV_HI = 4;
  localparam int CK_DIV_LO = 2;

  localparam logic [7:0] SETTINGS_RST = 8'h40;
  localparam logic [7:0] SETTINGS_WM  = 8'hE9;
  localparam logic [7:0] CLKSET_RST   = 8'h0C;
  localparam logic [7:0] CLKSET_WM    = 8'hFC;
  localparam logic [7:0] EARLY_HI_RST = 8'hAA;
  localparam logic [7:0] EARLY_LO_RST = 8'h00;
  localparam logic [7:0] EARLY_LO_WM  = 8'hC0;
  localparam logic [7:0] MUTE_HI_RST  = 8'hA4;
  localparam logic [7:0] MUTE_LO_RST  = 8'h74;

  localparam int SYS_CLK_HZ   = 40_000_000;
  localparam int INT_CLK_HZ   = 1_200_000;
  localparam int INT_HALF_CYC = SYS_CLK_HZ / (2 * INT_CLK_HZ);
endpackage : ss2_pkg
`default_nettype wire

// *** src/ss2_atr_timer.sv ***
// Answer-to-reset window timer counting card clock rising edges.
`default_nettype none
module ss2_atr_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        card_rise,
  input  wire logic        answer_seen,
  input  wire logic [9:0]  early_limit,
  input  wire logic [15:0] mute_limit,
  output logic             early_evt,
  output logic             mute_evt
);
  typedef enum logic [1:0] {
    SS2_IDLE = 2'b00,
    SS2_WAIT = 2'b01,
    SS2_DONE = 2'b10
  } ss2_tm_e;

  typedef struct packed {
    ss2_tm_e     st;
    logic [15:0] cnt;
    logic        early;
    logic        mute;
  } ss2_tm_s;

  ss2_tm_s q, d;

  always_comb begin
    d = q;
    d.early = 1'b0;
    d.mute  = 1'b0;
    if (abort) begin
      d.st = SS2_IDLE;
    end else if (start) begin
      d.st  = SS2_WAIT; // RULE_20
      d.cnt = 16'h0000;
    end else begin
      unique case (q.st)
        SS2_IDLE: d.st = SS2_IDLE;
        SS2_WAIT: begin
          if (answer_seen) begin
            d.early = (q.cnt < {6'h00, early_limit}); // RULE_02
            d.st    = SS2_DONE;
          end else if (q.cnt >= mute_limit) begin
            d.mute = 1'b1; // RULE_03
            d.st   = SS2_DONE;
          end else if (card_rise) begin
            d.cnt = q.cnt + 16'h0001; // RULE_20
          end
        end
        SS2_DONE: d.st = SS2_DONE;
        default:  d.st = SS2_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: SS2_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign early_evt = q.early;
  assign mute_evt  = q.mute;
endmodule : ss2_atr_timer
`default_nettype wire

// *** src/ss2_clkgen.sv ***
// Card clock generator: divider, internal clock and static levels.
`default_nettype none
module ss2_clkgen #(
  parameter int HALF_CYC = ss2_pkg::INT_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       in_clk,
  input  wire logic [2:0] div_sel,
  input  wire logic       int_sel,
  input  wire logic       hold_low,
  input  wire logic       hold_high,
  output logic            card_clk,
  output logic            card_rise
);
  typedef struct packed {
    logic       in_prev;
    logic [2:0] cnt;
    logic [7:0] int_cnt;
    logic       int_lvl;
    logic       out;
    logic       rise;
  } ss2_cg_s;

  ss2_cg_s q, d;
  logic [3:0] ratio;
  logic       div_lvl;

  always_comb begin
    d = q;
    d.in_prev = in_clk;
    unique case (div_sel)
      3'h0:    ratio = 4'h1;
      3'h1:    ratio = 4'h2;
      3'h2:    ratio = 4'h4;
      3'h3:    ratio = 4'h5;
      default: ratio = 4'h8;
    endcase
    if (in_clk && !q.in_prev) begin
      d.cnt = ({1'b0, q.cnt} >= ratio - 4'h1) ? 3'h0 : q.cnt + 3'h1; // RULE_16
    end
    div_lvl = (ratio == 4'h1) ? in_clk : ({1'b0, d.cnt} < (ratio >> 1)); // RULE_16
    if (q.int_cnt >= 8'(HALF_CYC - 1)) begin
      d.int_cnt = 8'h00;
      d.int_lvl = !q.int_lvl;
    end else begin
      d.int_cnt = q.int_cnt + 8'h01;
    end
    if (int_sel) begin
      d.out = q.int_lvl; // RULE_13
    end else if (hold_low) begin
      d.out = 1'b0; // RULE_14
    end else if (hold_high) begin
      d.out = 1'b1; // RULE_15
    end else begin
      d.out = div_lvl; // RULE_15
    end
    d.rise = d.out && !q.out;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign card_clk  = q.out;
  assign card_rise = q.rise;
endmodule : ss2_clkgen
`default_nettype wire

// *** src/ss2_regs.sv ***
// Register bank and slot control for the second secure access card slot.
// What this block does
// [RULE_01] Status bit 7 shows slot supply active.
// [RULE_02] Status bit 6 flags answer too early.
// [RULE_03] Status bit 5 flags answer missing.
// [RULE_04] Status bit 4 flags overcurrent.
// [RULE_05] Status bit 3 shows internal clock running.
// [RULE_06] Status bit 0 flags supply ramp fault.
// [RULE_07] Any fault flag sets interrupt summary.
// [RULE_08] Status read clears fault flags only.
// [RULE_09] Settings bits 7:6 select supply, reset 01.
// [RULE_10] Settings bit 5 connects data lines.
// [RULE_11] Settings bit 3 starts warm reset, self-clears.
// [RULE_12] Settings bit 0 activates; auto-deactivation clears.
// [RULE_13] Clock bit 7 selects internal clock.
// [RULE_14] Clock bit 6 holds card clock low.
// [RULE_15] Clock bit 5 holds high, else divider.
// [RULE_16] Divider field divides by 1,2,4,5,8.
// [RULE_17] Early limit high byte, reset AA.
// [RULE_18] Early limit low bits 7:6, reset 00.
// [RULE_19] Mute limit two bytes, reset A4/74.
// [RULE_20] Counters run from card reset release.
`default_nettype none
module ss2_regs (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       second_input_clock,
  input  wire logic       supply_stable,
  input  wire logic       overcurrent_detect,
  input  wire logic       ramp_fault_detect,
  input  wire logic       card_reset_release,
  input  wire logic       answer_start,
  input  wire logic       auto_deactivate,
  input  wire logic       warm_reset_begun,
  output logic            slot_interrupt_summary,
  output logic      [1:0] supply_select,
  output logic            activation_control,
  output logic            warm_reset_start,
  output logic            card_clock_out,
  input  wire logic       host_data_line_i,
  output logic            host_data_line_o,
  output logic            host_data_line_oe,
  input  wire logic       card_data_line_i,
  output logic            card_data_line_o,
  output logic            card_data_line_oe
);
  typedef struct packed {
    logic [7:0] settings;
    logic [7:0] clkset;
    logic [7:0] early_hi;
    logic [7:0] early_lo;
    logic [7:0] mute_hi;
    logic [7:0] mute_lo;
    logic       f_early;
    logic       f_mute;
    logic       f_oc;
    logic       f_ramp;
    logic       active;
    logic       intclk;
    logic [7:0] rdata;
    logic       card_drv;
    logic       host_drv;
  } ss2_rb_s;

  ss2_rb_s    q, d;
  logic       early_evt;
  logic       mute_evt;
  logic       card_rise;
  logic       rd_status;
  logic       wr_settings;
  logic [7:0] status;

  // The card clock generator runs on the system clock and samples the second input clock as a level.
  // Its output lags the settings by one edge, which the clock assertions below allow for.
  ss2_clkgen u_clkgen (
    .clk       (clk),
    .rst       (rst),
    .in_clk    (second_input_clock),
    .div_sel   (q.clkset[ss2_pkg::CK_DIV_HI:ss2_pkg::CK_DIV_LO]),
    .int_sel   (q.clkset[ss2_pkg::CK_INT]),
    .hold_low  (q.clkset[ss2_pkg::CK_LOW]),
    .hold_high (q.clkset[ss2_pkg::CK_HIGH]),
    .card_clk  (card_clock_out),
    .card_rise (card_rise)
  );

  // The answer window restarts on every card reset release while the activation bit is set and no automatic deactivation is present.
  // It is dropped as soon as the slot is deactivated, so a stale answer cannot raise a flag.
  ss2_atr_timer u_timer (
    .clk         (clk),
    .rst         (rst),
    .start       (card_reset_release),
    .abort       (auto_deactivate || !q.settings[ss2_pkg::SET_ACT]),
    .card_rise   (card_rise),
    .answer_seen (answer_start),
    .early_limit ({q.early_hi, q.early_lo[7:6]}), // RULE_17 RULE_18
    .mute_limit  ({q.mute_hi, q.mute_lo}), // RULE_19
    .early_evt   (early_evt),
    .mute_evt    (mute_evt)
  );

  assign rd_status   = reg_rd && (reg_addr == ss2_pkg::ADDR_STATUS);
  assign wr_settings = reg_wr && (reg_addr == ss2_pkg::ADDR_SETTINGS);

  always_comb begin
    status = 8'h00;
    status[ss2_pkg::ST_ACTIVE] = q.active;
    status[ss2_pkg::ST_EARLY]  = q.f_early;
    status[ss2_pkg::ST_MUTE]   = q.f_mute;
    status[ss2_pkg::ST_OC]     = q.f_oc;
    status[ss2_pkg::ST_INTCLK] = q.intclk;
    status[ss2_pkg::ST_RAMP]   = q.f_ramp;
  end

  always_comb begin
    d = q;
    d.active = supply_stable && q.settings[ss2_pkg::SET_ACT]; // RULE_01
    d.intclk = q.clkset[ss2_pkg::CK_INT]; // RULE_05
    // A read clears the fault flags, but an event in the same cycle wins.
    if (rd_status) begin
      d.f_early = 1'b0; // RULE_08
      d.f_mute  = 1'b0;
      d.f_oc    = 1'b0;
      d.f_ramp  = 1'b0;
    end
    if (early_evt) d.f_early = 1'b1; // RULE_02
    if (mute_evt) d.f_mute = 1'b1; // RULE_03
    if (overcurrent_detect) d.f_oc = 1'b1; // RULE_04
    if (ramp_fault_detect) d.f_ramp = 1'b1; // RULE_06
    if (warm_reset_begun) d.settings[ss2_pkg::SET_WARM] = 1'b0; // RULE_11
    if (reg_wr) begin
      unique case (reg_addr)
        ss2_pkg::ADDR_SETTINGS: d.settings = reg_wdata & ss2_pkg::SETTINGS_WM; // RULE_09 RULE_10 RULE_11 RULE_12
        ss2_pkg::ADDR_CLKSET:   d.clkset   = reg_wdata & ss2_pkg::CLKSET_WM;
        ss2_pkg::ADDR_EARLY_HI: d.early_hi = reg_wdata; // RULE_17
        ss2_pkg::ADDR_EARLY_LO: d.early_lo = reg_wdata & ss2_pkg::EARLY_LO_WM; // RULE_18
        ss2_pkg::ADDR_MUTE_HI:  d.mute_hi  = reg_wdata; // RULE_19
        ss2_pkg::ADDR_MUTE_LO:  d.mute_lo  = reg_wdata; // RULE_19
        default:                d.settings = d.settings;
      endcase
    end
    // Automatic deactivation overrides a simultaneous software write.
    if (auto_deactivate) d.settings[ss2_pkg::SET_ACT] = 1'b0; // RULE_12
    if (reg_rd) begin
      unique case (reg_addr)
        ss2_pkg::ADDR_STATUS:   d.rdata = status;
        ss2_pkg::ADDR_SETTINGS: d.rdata = q.settings;
        ss2_pkg::ADDR_CLKSET:   d.rdata = q.clkset;
        ss2_pkg::ADDR_EARLY_HI: d.rdata = q.early_hi;
        ss2_pkg::ADDR_EARLY_LO: d.rdata = q.early_lo;
        ss2_pkg::ADDR_MUTE_HI:  d.rdata = q.mute_hi;
        ss2_pkg::ADDR_MUTE_LO:  d.rdata = q.mute_lo;
        default:                d.rdata = 8'h00;
      endcase
    end
    // Open-drain bridge: the side that pulled low first owns the low level.
    if (!q.settings[ss2_pkg::SET_IOEN]) begin
      d.card_drv = 1'b0; // RULE_10
      d.host_drv = 1'b0;
    end else begin
      d.card_drv = !host_data_line_i && !q.host_drv; // RULE_10
      d.host_drv = !card_data_line_i && !q.card_drv;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q          <= '0;
      q.settings <= ss2_pkg::SETTINGS_RST;
      q.clkset   <= ss2_pkg::CLKSET_RST;
      q.early_hi <= ss2_pkg::EARLY_HI_RST;
      q.early_lo <= ss2_pkg::EARLY_LO_RST;
      q.mute_hi  <= ss2_pkg::MUTE_HI_RST;
      q.mute_lo  <= ss2_pkg::MUTE_LO_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata              = q.rdata;
  assign slot_interrupt_summary = q.f_early || q.f_mute || q.f_oc || q.f_ramp; // RULE_07
  assign supply_select          = q.settings[ss2_pkg::SET_VCC_HI:ss2_pkg::SET_VCC_LO]; // RULE_09
  assign activation_control     = q.settings[ss2_pkg::SET_ACT]; // RULE_12
  assign warm_reset_start       = q.settings[ss2_pkg::SET_WARM]; // RULE_11
  assign card_data_line_o       = 1'b0;
  assign card_data_line_oe      = q.card_drv;
  assign host_data_line_o       = 1'b0;
  assign host_data_line_oe      = q.host_drv;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  oc_flag_set_a: assert property (overcurrent_detect |=> status[ss2_pkg::ST_OC]) // RULE_04
    else $error("overcurrent did not set flag");
  ramp_flag_set_a: assert property (ramp_fault_detect |=> q.f_ramp) // RULE_06
    else $error("ramp fault did not set flag");
  read_clears_a: assert property (rd_status && !overcurrent_detect |=> !q.f_oc) // RULE_08
    else $error("status read did not clear overcurrent");
  read_keeps_a: assert property (rd_status && q.intclk && q.clkset[ss2_pkg::CK_INT] |=> q.intclk) // RULE_08
    else $error("status read cleared clock fallback");
  summary_flags_a: assert property ( // RULE_07
    early_evt || mute_evt || overcurrent_detect || ramp_fault_detect |=> slot_interrupt_summary)
    else $error("summary does not follow flags");
  intclk_status_a: assert property ($rose(q.clkset[ss2_pkg::CK_INT]) |=> status[ss2_pkg::ST_INTCLK]) // RULE_05
    else $error("clock fallback status late");
  warm_clear_a: assert property (warm_reset_begun && !reg_wr |=> !warm_reset_start) // RULE_11
    else $error("warm reset bit not cleared");
  auto_deact_a: assert property (auto_deactivate |=> !activation_control) // RULE_12
    else $error("auto deactivation did not clear bit");
  active_need_a: assert property (!supply_stable |=> !status[ss2_pkg::ST_ACTIVE]) // RULE_01
    else $error("active without stable supply");
  hold_low_a: assert property ( // RULE_14
    (!q.clkset[ss2_pkg::CK_INT] && q.clkset[ss2_pkg::CK_LOW]) [*3] |-> !card_clock_out)
    else $error("card clock not held low");
  io_off_a: assert property (!q.settings[ss2_pkg::SET_IOEN] |=> !card_data_line_oe && !host_data_line_oe) // RULE_10
    else $error("data line driven while disconnected");

  // Answer window events must reach their flags one edge later, even against a status read.
  early_flag_set_a: assert property (early_evt |=> status[ss2_pkg::ST_EARLY]) // RULE_02
    else $error("early answer did not set flag");
  mute_flag_set_a: assert property (mute_evt |=> status[ss2_pkg::ST_MUTE]) // RULE_03
    else $error("missing answer did not set flag");
  answer_clear_a: assert property (rd_status && !early_evt && !mute_evt |=> !q.f_early && !q.f_mute) // RULE_08
    else $error("status read did not clear answer flags");
  active_on_a: assert property (supply_stable && activation_control |=> status[ss2_pkg::ST_ACTIVE]) // RULE_01
    else $error("stable active slot not reported");
  intclk_off_a: assert property ($fell(q.clkset[ss2_pkg::CK_INT]) |=> !status[ss2_pkg::ST_INTCLK]) // RULE_05
    else $error("clock fallback status stuck");

  // A settings write lands in all its writable bits; only automatic deactivation may override its activation bit.
  supply_write_a: assert property (wr_settings |=> {supply_select, 6'h00} == ($past(reg_wdata) & 8'hC0)) // RULE_09
    else $error("supply selection not written");
  warm_write_a: assert property (wr_settings && reg_wdata[ss2_pkg::SET_WARM] |=> warm_reset_start) // RULE_11
    else $error("warm reset request lost");
  act_write_a: assert property ( // RULE_12
    wr_settings && !auto_deactivate |=> 8'(activation_control) == ($past(reg_wdata) & 8'h01))
    else $error("activation bit not written");
  abort_quiet_a: assert property (!activation_control |=> !early_evt && !mute_evt) // RULE_20
    else $error("answer event while slot deactivated");

  // Card clock sources: the static high level and the free running internal clock.
  hold_high_a: assert property ( // RULE_15
    (!q.clkset[ss2_pkg::CK_INT] && !q.clkset[ss2_pkg::CK_LOW] && q.clkset[ss2_pkg::CK_HIGH]) [*3] |-> card_clock_out)
    else $error("card clock not held high");
  int_clock_runs_a: assert property ( // RULE_13
    q.clkset[ss2_pkg::CK_INT] && card_rise |-> ##[1:40] (card_rise || !q.clkset[ss2_pkg::CK_INT]))
    else $error("internal card clock stalled");

  // While connected, a low on either data line is passed to the other side one edge later.
  host_bridge_a: assert property ( // RULE_10
    q.settings[ss2_pkg::SET_IOEN] && !card_data_line_i && !card_data_line_oe |=> host_data_line_oe)
    else $error("card low not passed to host side");
  card_bridge_a: assert property ( // RULE_10
    q.settings[ss2_pkg::SET_IOEN] && !host_data_line_i && !host_data_line_oe |=> card_data_line_oe)
    else $error("host low not passed to card side");
endmodule : ss2_regs
`default_nettype wire
